/* iqc_defines.svh */
// Purpose: Offsets, field positions, reset values for the correction registers
// Assumes: Register indices are word indices; byte address is four times index
// Notes:   Definitions only
`ifndef IQC_DEFINES_SVH
`define IQC_DEFINES_SVH

// Register indices (byte address = index * 4)
`define IQC_IDX_OFS_C     10'h00a
`define IQC_IDX_OFS_D     10'h00b
`define IQC_IDX_GAIN_A    10'h00c
`define IQC_IDX_MIX_GAINB 10'h00d
`define IQC_IDX_GAIN_C    10'h00e
`define IQC_IDX_SYNC_CTRL 10'h01e
`define IQC_IDX_ACT_OFS   10'h01f

// Field positions
`define IQC_OFS_MSB       12
`define IQC_GAIN_MSB      10
`define IQC_GAIN_FRAC     10
`define IQC_MIX_MSB       15
`define IQC_MIX_LSB       12
`define IQC_SYNC_EN_BIT   0
`define IQC_SYNC_NOW_BIT  1
`define IQC_ACT_D_LSB     16

// Reset values
`define IQC_OFS_RST       13'h0000
`define IQC_GAIN_RST      11'h400
`define IQC_MIX_RST       4'h0

// Coarse mixer phase steps, in eighths of a turn per sample
`define IQC_STEP_FS8      3'h1
`define IQC_STEP_FS4      3'h2
`define IQC_STEP_FS2      3'h4
`define IQC_STEP_NFS4     3'h6

// cos(45 deg) in Q1.15
`define IQC_COS45         16'h5a82
`define IQC_COS45_FRAC    15

`endif

/* iqc_pkg.sv */
// Purpose: Types shared by the correction register bank and its datapath
// Assumes: Four channels of 16-bit signed samples
// Notes:   Constants live in iqc_defines.svh
package iqc_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef logic signed [15:0] sample_type;

   // Index 0 is channel A, 3 is channel D
   typedef sample_type [3:0] quad_type;

endpackage

/* iqc_chan_corr.sv */
// Purpose: Gain and offset correction of one channel
// Assumes: Gain is unsigned Q1.10, offset is signed in converter LSBs
// Notes:   Result saturates to the sample width; one cycle of latency
`timescale 1ns/1ns
`default_nettype none
`include "iqc_defines.svh"
module iqc_chan_corr #(
   parameter int SW = 16,
   parameter int GW = 11,
   parameter int OW = 13
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic signed [SW-1:0] sampleIn,
   input  wire logic        [GW-1:0] gainWord,
   input  wire logic signed [OW-1:0] offsetWord,
   output var  logic signed [SW-1:0] sampleOut
);
   logic signed [SW+GW:0]   product;
   logic signed [SW+GW:0]   scaled;
   logic signed [SW+GW+1:0] summed;
   logic signed [SW-1:0]    sampleOut_next;
   localparam logic signed [SW+GW+1:0] MAXV = (2 ** (SW - 1)) - 1;
   localparam logic signed [SW+GW+1:0] MINV = -(2 ** (SW - 1));

   always_comb begin
      // Binary point sits between bit 9 and bit 10 of the gain
      product = sampleIn * $signed({1'b0, gainWord});
      scaled  = product >>> `IQC_GAIN_FRAC;
      summed  = (SW+GW+2)'(scaled) + (SW+GW+2)'(offsetWord);
      if (summed > MAXV) begin
         sampleOut_next = MAXV[SW-1:0];
      end else if (summed < MINV) begin
         sampleOut_next = MINV[SW-1:0];
      end else begin
         sampleOut_next = summed[SW-1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sampleOut <= '0;
      end else begin
         sampleOut <= sampleOut_next;
      end
   end
endmodule
`default_nettype wire

/* iqc_offset_gain_regs.sv */
// Purpose: APB register bank for channel C/D offset, channel A/B/C gain and
//          coarse mixer selection, with the correction datapath it steers
// Assumes: Samples arrive on clk every cycle; APB3 slave with no wait states
// Notes:   Channel A/B offsets and channel D gain are held neutral here
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "iqc_defines.svh"
// Function
// - Channel C has a 13-bit offset in bits 12:0, in LSBs, added to C samples.
// - Channel D has a 13-bit offset in bits 12:0, in LSBs, for the D path.
// - With auto-sync enabled, writing the C offset register fires a sync.
// - That sync moves the C and D offsets into the datapath in one cycle.
// - Writing only the D offset leaves the applied offset unchanged.
// - Channel A has an 11-bit unsigned gain in bits 10:0 that scales A.
// - Channel B has an 11-bit unsigned gain in bits 10:0 that scales B.
// - Channel C has an 11-bit unsigned gain in bits 10:0 that scales C.
// - Each gain word has one integer bit and ten fraction bits.
// - Gain registers reset to 0x0400, a gain of one.
// - The C offset register resets to zero, so no offset is applied.
// - Mixer bits 15, 14, 13, 12 enable the Fs/8, Fs/4, Fs/2, -Fs/4 stages.
// - Enabled stages combine into one shift that is a multiple of Fs/8.
module iqc_offset_gain_regs (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire iqc_pkg::apb_req_type apbReq,
   output var  logic [31:0]          prdata,
   output var  logic                 pready,
   output var  logic                 pslverr,
   input  wire iqc_pkg::quad_type    sampleIn,
   output var  iqc_pkg::quad_type    sampleOut,
   output var  logic                 offsetSyncPulse
);

   logic [9:0]  regIdx;
   logic        setupPhase;
   logic        accessWrite;
   logic        wrOfsC;
   logic        wrSync;
   logic        syncEvent;

   logic [12:0] ofsC_reg;
   logic [12:0] ofsC_next;
   logic [12:0] ofsD_reg;
   logic [12:0] ofsD_next;
   logic [10:0] gainA_reg;
   logic [10:0] gainA_next;
   logic [10:0] gainB_reg;
   logic [10:0] gainB_next;
   logic [10:0] gainC_reg;
   logic [10:0] gainC_next;
   logic [3:0]  mix_reg;
   logic [3:0]  mix_next;
   logic        syncEn_reg;
   logic        syncEn_next;

   logic [12:0] actOfsC_reg;
   logic [12:0] actOfsC_next;
   logic [12:0] actOfsD_reg;
   logic [12:0] actOfsD_next;
   logic        syncPulse_reg;
   logic        syncPulse_next;

   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        err_reg;
   logic        err_next;

   logic [2:0]  mixStep;
   logic [2:0]  phase_reg;
   logic [2:0]  phase_next;

   iqc_pkg::quad_type corrOut;
   iqc_pkg::quad_type mixOut_reg;
   iqc_pkg::quad_type mixOut_next;

   logic [10:0]       gainSel [4];
   logic signed [12:0] ofsSel [4];

   // Bus decode
   assign regIdx      = apbReq.paddr[11:2];
   assign setupPhase  = apbReq.psel && !apbReq.penable;
   // Zero wait states: every access phase completes at once
   assign pready      = 1'b1;
   assign accessWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign wrOfsC      = accessWrite && (regIdx == `IQC_IDX_OFS_C);
   assign wrSync      = accessWrite && (regIdx == `IQC_IDX_SYNC_CTRL)
                        && apbReq.pwdata[`IQC_SYNC_NOW_BIT];
   // Sync on a C offset write only when enabled
   assign syncEvent   = (wrOfsC && syncEn_reg) || wrSync;
   assign prdata      = rdata_reg;
   assign pslverr     = err_reg;
   assign offsetSyncPulse = syncPulse_reg;
   assign sampleOut   = mixOut_reg;

   // Software-written registers
   always_comb begin
      ofsC_next   = ofsC_reg;
      ofsD_next   = ofsD_reg;
      gainA_next  = gainA_reg;
      gainB_next  = gainB_reg;
      gainC_next  = gainC_reg;
      mix_next    = mix_reg;
      syncEn_next = syncEn_reg;
      if (accessWrite) begin
         // Reserved bits are simply not stored
         unique case (regIdx)
            `IQC_IDX_OFS_C: begin
               ofsC_next = apbReq.pwdata[`IQC_OFS_MSB:0];
            end
            `IQC_IDX_OFS_D: begin
               ofsD_next = apbReq.pwdata[`IQC_OFS_MSB:0];
            end
            `IQC_IDX_GAIN_A: begin
               gainA_next = apbReq.pwdata[`IQC_GAIN_MSB:0];
            end
            `IQC_IDX_MIX_GAINB: begin
               gainB_next = apbReq.pwdata[`IQC_GAIN_MSB:0];
               mix_next = apbReq.pwdata[`IQC_MIX_MSB:`IQC_MIX_LSB];
            end
            `IQC_IDX_GAIN_C: begin
               gainC_next = apbReq.pwdata[`IQC_GAIN_MSB:0];
            end
            `IQC_IDX_SYNC_CTRL: begin
               syncEn_next = apbReq.pwdata[`IQC_SYNC_EN_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ofsC_reg   <= `IQC_OFS_RST;
         ofsD_reg   <= `IQC_OFS_RST;
         gainA_reg  <= `IQC_GAIN_RST;
         gainB_reg  <= `IQC_GAIN_RST;
         gainC_reg  <= `IQC_GAIN_RST;
         mix_reg    <= `IQC_MIX_RST;
         syncEn_reg <= 1'b0;
      end else begin
         ofsC_reg   <= ofsC_next;
         ofsD_reg   <= ofsD_next;
         gainA_reg  <= gainA_next;
         gainB_reg  <= gainB_next;
         gainC_reg  <= gainC_next;
         mix_reg    <= mix_next;
         syncEn_reg <= syncEn_next;
      end
   end

   // Applied offsets, loaded as a pair by the sync
   always_comb begin
      actOfsC_next   = actOfsC_reg;
      actOfsD_next   = actOfsD_reg;
      syncPulse_next = syncEvent;
      if (syncEvent) begin
         // The C word is taken from the bus so a C write lands with it;
         // D is the stored value, so D must be written before C
         actOfsC_next = wrOfsC ? apbReq.pwdata[`IQC_OFS_MSB:0] : ofsC_reg;
         actOfsD_next = ofsD_reg;
      end
      // A D write alone never reaches the datapath
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         actOfsC_reg   <= `IQC_OFS_RST;
         actOfsD_reg   <= `IQC_OFS_RST;
         syncPulse_reg <= 1'b0;
      end else begin
         actOfsC_reg   <= actOfsC_next;
         actOfsD_reg   <= actOfsD_next;
         syncPulse_reg <= syncPulse_next;
      end
   end

   // Read data is registered in the setup cycle
   always_comb begin
      rdata_next = rdata_reg;
      err_next   = 1'b0;
      if (setupPhase) begin
         rdata_next = '0;
         // Upper and reserved bits fill with zero
         unique case (regIdx)
            `IQC_IDX_OFS_C: begin
               rdata_next[`IQC_OFS_MSB:0] = ofsC_reg;
            end
            `IQC_IDX_OFS_D: begin
               rdata_next[`IQC_OFS_MSB:0] = ofsD_reg;
            end
            `IQC_IDX_GAIN_A: begin
               rdata_next[`IQC_GAIN_MSB:0] = gainA_reg;
            end
            `IQC_IDX_MIX_GAINB: begin
               rdata_next[`IQC_GAIN_MSB:0] = gainB_reg;
               rdata_next[`IQC_MIX_MSB:`IQC_MIX_LSB] = mix_reg;
            end
            `IQC_IDX_GAIN_C: begin
               rdata_next[`IQC_GAIN_MSB:0] = gainC_reg;
            end
            `IQC_IDX_SYNC_CTRL: begin
               rdata_next[`IQC_SYNC_EN_BIT] = syncEn_reg;
            end
            `IQC_IDX_ACT_OFS: begin
               rdata_next[`IQC_OFS_MSB:0] = actOfsC_reg;
               rdata_next[`IQC_ACT_D_LSB +: 13] = actOfsD_reg;
            end
            default: begin
               err_next = 1'b1;
            end
         endcase
      end else if (apbReq.psel) begin
         err_next = err_reg;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= '0;
         err_reg   <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         err_reg   <= err_next;
      end
   end

   // Per-channel gain and offset; D gain and A/B offsets are neutral
   assign gainSel[0] = gainA_reg;
   assign gainSel[1] = gainB_reg;
   assign gainSel[2] = gainC_reg;
   assign gainSel[3] = `IQC_GAIN_RST;
   assign ofsSel[0]  = `IQC_OFS_RST;
   assign ofsSel[1]  = `IQC_OFS_RST;
   assign ofsSel[2]  = actOfsC_reg;
   assign ofsSel[3]  = actOfsD_reg;

   for (genvar ch = 0; ch < 4; ch++) begin : g_chan
      iqc_chan_corr #(
         .SW (16),
         .GW (11),
         .OW (13)
      ) u_corr (
         .clk        (clk),
         .nrst       (nrst),
         .sampleIn   (sampleIn[ch]),
         .gainWord   (gainSel[ch]),
         .offsetWord (ofsSel[ch]),
         .sampleOut  (corrOut[ch])
      );
   end

   // Clamp a 17-bit value into a sample
   function automatic iqc_pkg::sample_type sat17(
      input logic signed [16:0] v
   );
      if (v > 17'sh07fff) begin
         sat17 = 16'sh7fff;
      end else if (v < -17'sh08000) begin
         sat17 = 16'sh8000;
      end else begin
         sat17 = v[15:0];
      end
   endfunction

   // Rotate I/Q by k eighths of a turn
   function automatic logic [31:0] rot8(
      input iqc_pkg::sample_type i,
      input iqc_pkg::sample_type q,
      input logic [2:0]          k
   );
      logic signed [16:0] ri;
      logic signed [16:0] rq;
      logic signed [33:0] pi;
      logic signed [33:0] pq;
      ri = '0;
      rq = '0;
      pi = '0;
      pq = '0;
      unique case (k[2:1])
         2'h0: begin
            ri = 17'(i);
            rq = 17'(q);
         end
         2'h1: begin
            ri = -17'(q);
            rq = 17'(i);
         end
         2'h2: begin
            ri = -17'(i);
            rq = -17'(q);
         end
         2'h3: begin
            ri = 17'(q);
            rq = -17'(i);
         end
      endcase
      if (k[0]) begin
         // Odd steps cost a multiply; even steps are free sign swaps
         // Widen before the add so a full-scale pair cannot wrap
         pi = (34'(ri) - 34'(rq)) * $signed({1'b0, `IQC_COS45});
         pq = (34'(ri) + 34'(rq)) * $signed({1'b0, `IQC_COS45});
         ri = 17'(pi >>> `IQC_COS45_FRAC);
         rq = 17'(pq >>> `IQC_COS45_FRAC);
      end
      rot8 = {sat17(ri), sat17(rq)};
   endfunction

   // Enabled stages add their steps, wrapping in eighths
   assign mixStep = (mix_reg[3] ? `IQC_STEP_FS8  : 3'h0)
                  + (mix_reg[2] ? `IQC_STEP_FS4  : 3'h0)
                  + (mix_reg[1] ? `IQC_STEP_FS2  : 3'h0)
                  + (mix_reg[0] ? `IQC_STEP_NFS4 : 3'h0);

   always_comb begin
      phase_next = phase_reg + mixStep;
      {mixOut_next[0], mixOut_next[1]} =
         rot8(corrOut[0], corrOut[1], phase_reg);
      {mixOut_next[2], mixOut_next[3]} =
         rot8(corrOut[2], corrOut[3], phase_reg);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_reg  <= 3'h0;
         mixOut_reg <= '0;
      end else begin
         phase_reg  <= phase_next;
         mixOut_reg <= mixOut_next;
      end
   end

endmodule
`default_nettype wire

/* iqc_offset_gain_regs_assertions.sv */
// Purpose: Checker for the correction register bank
// Assumes: Bound to iqc_offset_gain_regs, zero-wait APB
// Notes:   Mirrors stored and applied C/D offsets in helper logic
`timescale 1ns/1ns
`default_nettype none
module iqc_offset_gain_regs_assertions (
   input wire logic                 clk,
   input wire logic                 nrst,
   input wire iqc_pkg::apb_req_type apbReq,
   input wire logic [31:0]          prdata,
   input wire logic                 pslverr,
   input wire logic                 offsetSyncPulse
);
   logic [9:0]  idx;
   logic        wr, rd, cWr, syn, known;
   logic [12:0] ofsC_reg, ofsD_reg, actC_reg, actD_reg;
   logic [12:0] ofsC_next, ofsD_next, actC_next, actD_next;
   logic        en_reg, en_next;
   assign idx = apbReq.paddr[11:2];
   assign wr = apbReq.psel & apbReq.penable & apbReq.pwrite;
   assign rd = apbReq.psel & apbReq.penable & !apbReq.pwrite;
   assign cWr = wr && idx == 10'h00a;
   assign syn = (cWr && en_reg) || (wr && idx == 10'h01e && apbReq.pwdata[1]);
   assign known = idx inside {[10'h00a:10'h00e], 10'h01e, 10'h01f};
   always_comb begin
      ofsC_next = cWr ? apbReq.pwdata[12:0] : ofsC_reg;
      ofsD_next = (wr && idx == 10'h00b) ? apbReq.pwdata[12:0] : ofsD_reg;
      en_next = (wr && idx == 10'h01e) ? apbReq.pwdata[0] : en_reg;
      // A C write with sync applies the new C word, not the old one
      actC_next = syn ? ofsC_next : actC_reg;
      actD_next = syn ? ofsD_reg : actD_reg;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ofsC_reg <= '0;
         ofsD_reg <= '0;
         actC_reg <= '0;
         actD_reg <= '0;
         en_reg <= 1'b0;
      end else begin
         ofsC_reg <= ofsC_next;
         ofsD_reg <= ofsD_next;
         actC_reg <= actC_next;
         actD_reg <= actD_next;
         en_reg <= en_next;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   property p_sync_c;
      cWr && en_reg |=> offsetSyncPulse;
   endproperty
   a_sync_c: assert property (p_sync_c) else $error("no sync pulse");
   property p_sync_why;
      offsetSyncPulse |-> $past(syn);
   endproperty
   a_sync_why: assert property (p_sync_why) else $error("stray sync");
   property p_act;
      rd && idx == 10'h01f |-> prdata == {3'h0, actD_reg, 3'h0, actC_reg};
   endproperty
   a_act: assert property (p_act) else $error("applied pair wrong");
   property p_ofs_c;
      rd && idx == 10'h00a |-> prdata == {19'h0, ofsC_reg};
   endproperty
   a_ofs_c: assert property (p_ofs_c) else $error("C offset wrong");
   property p_ofs_d;
      rd && idx == 10'h00b |-> prdata == {19'h0, ofsD_reg};
   endproperty
   a_ofs_d: assert property (p_ofs_d) else $error("D offset wrong");
   property p_gain;
      rd && (idx == 10'h00c || idx == 10'h00e) |-> prdata[31:11] == '0;
   endproperty
   a_gain: assert property (p_gain) else $error("gain spare bits");
   property p_mix;
      rd && idx == 10'h00d |-> prdata[31:16] == '0 && !prdata[11];
   endproperty
   a_mix: assert property (p_mix) else $error("mixer spare bits");
   property p_unmap;
      apbReq.psel && apbReq.penable && !known
         |-> pslverr && (apbReq.pwrite || prdata == '0);
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access");
endmodule
bind iqc_offset_gain_regs iqc_offset_gain_regs_assertions
   u_iqc_offset_gain_regs_assertions (.clk(clk), .nrst(nrst),
   .apbReq(apbReq), .prdata(prdata), .pslverr(pslverr),
   .offsetSyncPulse(offsetSyncPulse));
`default_nettype wire

/* iqc_offset_gain_regs_tb.sv */
// Purpose: Self-checking bench for the correction register bank
// Assumes: Zero-wait APB slave, two-cycle datapath
// Notes:   Mixer is checked by the phase step between outputs
`timescale 1ns/1ns
`default_nettype none
`include "iqc_defines.svh"
module iqc_offset_gain_regs_tb;
   logic                 clk, nrst, pready, pslverr, offsetSyncPulse, rerr;
   logic [31:0]          prdata, rdat, wd;
   iqc_pkg::apb_req_type apbReq;
   iqc_pkg::quad_type    sIn, sOut, z0, zE;
   int                   mismatches, checks, seed, i, m, k;
   logic [15:0]          sh [10:14];
   iqc_offset_gain_regs u_iqc_offset_gain_regs (.clk(clk), .nrst(nrst),
      .apbReq(apbReq), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sampleIn(sIn), .sampleOut(sOut),
      .offsetSyncPulse(offsetSyncPulse));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic complete_run;
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chks(input iqc_pkg::sample_type got, exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input int a, input logic [31:0] d);
      @(posedge clk);
      apbReq <= '{1'b1, 1'b0, w, {a[9:0], 2'b00}, d};
      @(posedge clk);
      apbReq <= '{1'b1, 1'b1, w, {a[9:0], 2'b00}, d};
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      apbReq <= '{1'b0, 1'b0, w, {a[9:0], 2'b00}, d};
   endtask
   function automatic logic [15:0] msk(input int a);
      if (a < 12) return 16'h1fff;
      if (a == 13) return 16'hf7ff;
      return 16'h07ff;
   endfunction
   task automatic wr(input int a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a > 9 && a < 15) sh[a] = d[15:0] & msk(a);
   endtask
   task automatic rdc(input int a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   function automatic iqc_pkg::sample_type corr(iqc_pkg::sample_type s,
      logic [10:0] g, logic [12:0] o);
      logic signed [27:0] p;
      p = (s * $signed({1'b0, g})) >>> 10;
      p = p + $signed(o);
      if (p > 28'sh7fff) return 16'sh7fff;
      if (p < -28'sh8000) return 16'sh8000;
      return p[15:0];
   endfunction
   function automatic iqc_pkg::sample_type ex(input int c);
      case (c)
         0: return corr(sIn[0], sh[12][10:0], 13'h0);
         1: return corr(sIn[1], sh[13][10:0], 13'h0);
         2: return corr(sIn[2], sh[14][10:0], sh[10][12:0]);
         default: return corr(sIn[3], 11'h400, sh[11][12:0]);
      endcase
   endfunction
   function automatic int stp(input logic [3:0] b);
      return (b[3] + 2 * b[2] + 4 * b[1] + 6 * b[0]) % 8;
   endfunction
   // Quarter-turn steps only; odd phases round and are checked by period
   function automatic iqc_pkg::quad_type rot(iqc_pkg::quad_type z, int k);
      iqc_pkg::quad_type   r;
      iqc_pkg::sample_type t;
      r = z;
      for (int n = 0; n < k / 2; n++) begin
         for (int c = 0; c < 4; c += 2) begin
            t = r[c];
            r[c] = -r[c + 1];
            r[c + 1] = t;
         end
      end
      return r;
   endfunction
   // Expected mixer output at phase p eighths; odd phases add 45 degrees
   function automatic iqc_pkg::quad_type mixx(iqc_pkg::quad_type z, int p);
      iqc_pkg::quad_type r;
      int                a;
      int                b;
      r = rot(z, p % 8 - p % 2);
      if (p % 2) begin
         for (int c = 0; c < 4; c += 2) begin
            a = (int'(r[c]) - int'(r[c + 1])) * int'(`IQC_COS45);
            b = (int'(r[c]) + int'(r[c + 1])) * int'(`IQC_COS45);
            r[c] = 16'(a >>> `IQC_COS45_FRAC);
            r[c + 1] = 16'(b >>> `IQC_COS45_FRAC);
         end
      end
      return r;
   endfunction
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run;
   end
   initial begin
      seed = 67;
      mismatches = 0;
      checks = 0;
      nrst = 1'b0;
      apbReq = '0;
      sIn = '0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      for (i = 10; i < 15; i++) begin
         sh[i] = (i < 12) ? 16'h0000 : 16'h0400;
         rdc(i, {16'h0, sh[i]});
      end
      rdc(31, 32'h0);
      wr(10, 32'h0155);
      rdc(31, 32'h0);
      wr(30, 32'h1);
      wr(11, 32'h0123);
      rdc(31, 32'h0);
      wr(10, 32'h1abc);
      @(negedge clk);
      chk({31'h0, offsetSyncPulse}, 32'h1);
      rdc(31, 32'h0123_1abc);
      wr(11, 32'h1f00);
      wr(30, 32'h2);
      rdc(31, 32'h1f00_1abc);
      for (i = 0; i < 40; i++) begin
         m = 10 + $unsigned($random(seed)) % 5;
         wd = $random(seed);
         if (m == 13) wd[15:12] = 4'h0;
         wr(m, wd);
         m = 10 + $unsigned($random(seed)) % 5;
         rdc(m, {16'h0, sh[m]});
      end
      wr(12, 32'hffff_f7ff);
      wr(30, 32'h3);
      for (i = 0; i < 30; i++) begin
         @(posedge clk);
         if (i < 2) begin
            sIn <= {4{i ? 16'h8000 : 16'h7fff}};
         end else begin
            sIn <= {16'($random(seed)), 16'($random(seed)),
                    16'($random(seed)), 16'($random(seed))};
         end
         repeat (3) @(negedge clk);
         for (int c = 0; c < 4; c++) chks(sOut[c], ex(c));
      end
      for (i = 10; i < 15; i++) begin
         wr(i, 32'hffff_ffff);
         rdc(i, {16'h0, sh[i]});
      end
      rdc(3, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      sIn <= {16'h07d0, 16'hfe0c, 16'h012c, 16'h03e8};
      for (m = 0; m < 16; m++) begin
         @(posedge clk);
         nrst <= 1'b0;
         @(posedge clk);
         nrst <= 1'b1;
         rdc(14, 32'h0400);
         wr(13, {16'h0, m[3:0], 12'h400});
         repeat (4) @(negedge clk);
         z0 = sOut;
         k = stp(m[3:0]);
         zE = mixx(sIn, 2 * k);
         for (int c = 0; c < 4; c++) chks(z0[c], zE[c]);
         repeat (k % 2 ? 8 : 1) @(negedge clk);
         if (k % 2 == 0) z0 = rot(z0, k);
         for (int c = 0; c < 4; c++) chks(sOut[c], z0[c]);
         // One more step lands on an odd phase when k is odd
         @(negedge clk);
         zE = mixx(sIn, (k % 2 ? 11 : 4) * k);
         for (int c = 0; c < 4; c++) chks(sOut[c], zE[c]);
      end
      complete_run;
   end
endmodule
`default_nettype wire
